// file: verilog/ulp_params.svh
// Purpose: constants of the usb endpoint-0 block
// Assumes: 8-bit register space
// Notes: offsets, fields, counts
//
// Summary of operation
// [R1] Status bit 7 sets expected DATA0/DATA1; compared with received PID.
// [R2] Setup flag, status bit 6, set on token PID b1101.
// [R3] In flag, status bit 5, set on an IN token.
// [R4] Out flag, status bit 4, set on an OUT token.
// [R5] Status bits 3..0 count bytes of the latest accepted DATA packet.
// [R6] Endpoint-0 received bytes read at 0EFh.
// [R7] Endpoint-0 transmit byte written at 0E7h.
// [R8] Endpoint-1 transmit byte written at 0E6h.
// [R9] USB clock is core clock halved, divided by prescaler plus one.
// [R10] Software sets the prescaler for a 6 MHz USB clock.
// [R11] Only 12, 24 or 36 MHz core clocks, prescaler 0, 1 or 2.
// [R12] Data-line driver released unless transmitting.
// [R13] Select bit routes the endpoint-1 transmit register to endpoint 1 or 2.
// [R14] Token flags update together; only the latest token's flag is set.
`ifndef ULP_PARAMS_SVH
`define ULP_PARAMS_SVH

// register offsets
`define ULP_ADDR_PRESCALER 8'hE1
`define ULP_ADDR_EP1_TX_DATA 8'hE6
`define ULP_ADDR_EP0_TX_DATA 8'hE7
`define ULP_ADDR_EVENT_FLAGS 8'hE8
`define ULP_ADDR_EVENT_ENABLES 8'hE9
`define ULP_ADDR_EP0_TX_CTRL 8'hEA
`define ULP_ADDR_EP1_TX_CTRL 8'hEB
`define ULP_ADDR_EP_CTRL 8'hEC
`define ULP_ADDR_EP0_STATUS 8'hED
`define ULP_ADDR_FUNC_ADDR 8'hEE
`define ULP_ADDR_EP0_RX_DATA 8'hEF

// reset values
`define ULP_RST_BYTE 8'h00

// field positions
`define ULP_STA_SEQ 7
`define ULP_STA_SETUP 6
`define ULP_STA_IN 5
`define ULP_STA_OUT 4
`define ULP_CTL_TSEQ 7
`define ULP_CTL1_EPSEL 6
`define ULP_CTL_TXE 5
`define ULP_EPC_EP2E 3
`define ULP_EPC_EP1E 2
`define ULP_ADR_USBEN 7

// packet ids
`define ULP_PID_SETUP 4'b1101
`define ULP_PID_IN 4'b1001
`define ULP_PID_OUT 4'b0001
`define ULP_PID_DATA0 4'b0011
`define ULP_PID_DATA1 4'b1011
`define ULP_SYNC_BYTE 8'h80

// timing counts and sizes
`define ULP_SAMPLE_PHASE 2'h2
`define ULP_STUFF_RUN 3'h6
`define ULP_TX_LAST_BIT 5'h17
`define ULP_FIFO_DEPTH 16
`define ULP_TOKEN_BYTES 4'h3

`endif

// file: verilog/ulp_pkg.sv
// Purpose: types of the usb endpoint-0 block
// Assumes: constants in ulp_params.svh
// Notes: state is one packed struct
package ulp_pkg;

    // link states, one-bit steps from idle through sync to recv and from send to eop
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SYNC = 3'b001,
        ST_RECV = 3'b011,
        ST_SEND = 3'b100,
        ST_EOP = 3'b110
    } ulp_state_type;

    // register access
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ulp_sfr_req_type;

    // differential line pair
    typedef struct packed {
        logic dp;
        logic dm;
    } ulp_line_type;

    // complete block state
    typedef struct packed {
        ulp_state_type st;
        logic [8:0] div_cnt;
        logic [1:0] phase;
        ulp_line_type line_prev;
        logic rx_last;
        logic [2:0] ones;
        logic [7:0] shift;
        logic [2:0] bitcnt;
        logic [3:0] byte_idx;
        logic [3:0] pid;
        logic [7:0] tk0;
        logic [7:0] hold1;
        logic [7:0] hold2;
        logic data_ok;
        logic last_ep0_out;
        logic [3:0] cnt;
        logic seq_match;
        logic [7:0] prescaler;
        logic [7:0] ep0_tx_data;
        logic [7:0] ep1_tx_data;
        logic [7:0] event_enables;
        logic [7:0] ep0_tx_ctrl;
        logic [7:0] ep1_tx_ctrl;
        logic [7:0] ep_ctrl;
        logic [7:0] status;
        logic [7:0] func_addr;
        logic [7:0] rdata;
        logic [23:0] tx_shift;
        logic [4:0] tx_bits;
        logic [2:0] tx_ones;
        logic [1:0] eop_cnt;
        ulp_line_type drive;
        logic oe_n;
    } ulp_state_struct_type;

endpackage : ulp_pkg

// file: verilog/ulp_fifo.sv
// Purpose: receive byte buffer
// Assumes: depth a power of two
// Notes: push and pop may share a cycle
`timescale 1ns/1ps
`default_nettype none
module ulp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    // extra pointer bit tells full from empty
    assign out_valid_o = (wr_ptr_reg != rd_ptr_reg);
    assign in_ready_o = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_reg[AW-1:0]];

    // storage has no reset, pointers do
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW + 1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW + 1)'(pop);
        end
    end
endmodule : ulp_fifo
`default_nettype wire

// file: verilog/ulp_core.sv
// Purpose: usb endpoint-0 registers and bit engine
// Assumes: line inputs synchronous; one access per cycle
// Notes: no crc; transmit is sync, data pid, one byte
`timescale 1ns/1ps
`default_nettype none
`include "ulp_params.svh"
module ulp_core (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // special-function register port
    input wire ulp_pkg::ulp_sfr_req_type sfr_i,
    output logic [7:0] sfr_rdata_o,
    // usb data lines
    input wire ulp_pkg::ulp_line_type line_i,
    output ulp_pkg::ulp_line_type line_o,
    output logic line_oe_n_o,
    // status
    output logic usb_clk_en_o,
    output logic ep0_rx_seq_match_o
);
    ulp_pkg::ulp_state_struct_type s_reg;
    ulp_pkg::ulp_state_struct_type s_next;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [7:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;

    // pid against its complement
    function automatic logic is_pid(input logic [7:0] b, input logic [3:0] p);
        is_pid = (b[3:0] == p) && (b[7:4] == ~p);
    endfunction : is_pid

    // data pid byte for a sequence bit
    function automatic logic [7:0] data_pid_byte(input logic seq);
        logic [3:0] p;
        p = seq ? `ULP_PID_DATA1 : `ULP_PID_DATA0;
        data_pid_byte = {~p, p};
    endfunction : data_pid_byte

    ulp_fifo #(
        .WIDTH(8),
        .DEPTH(`ULP_FIFO_DEPTH)
    ) u_rx_fifo (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // reading receive data pops a byte
    assign fifo_out_ready = sfr_i.rd && (sfr_i.addr == `ULP_ADDR_EP0_RX_DATA); // R6

    always_comb begin
        logic usb_en;
        logic bit_en;
        logic se0;
        logic rx_bit;
        logic [7:0] b;
        logic [6:0] tok_addr;
        logic [3:0] tok_ep;
        logic is_setup;
        logic is_in;
        logic is_out;
        logic ep1_go;
        logic ep2_go;
        logic tx_bit;
        usb_en = 1'b0;
        bit_en = 1'b0;
        se0 = 1'b0;
        rx_bit = 1'b0;
        b = 8'h00;
        tok_addr = 7'h00;
        tok_ep = 4'h0;
        is_setup = 1'b0;
        is_in = 1'b0;
        is_out = 1'b0;
        ep1_go = 1'b0;
        ep2_go = 1'b0;
        tx_bit = 1'b0;
        fifo_in_valid = 1'b0;
        fifo_in_data = s_reg.hold2;
        s_next = s_reg;

        // divider: halve, then prescaler plus one
        if (s_reg.div_cnt >= {s_reg.prescaler, 1'b1}) begin // R9
            s_next.div_cnt = 9'h000;
            usb_en = 1'b1;
        end else begin
            s_next.div_cnt = s_reg.div_cnt + 9'h001;
        end

        // four usb clocks a bit; resync on edges except in send
        s_next.line_prev = line_i;
        if (line_i != s_reg.line_prev && s_reg.st != ulp_pkg::ST_SEND) begin
            s_next.phase = 2'h0;
        end else if (usb_en) begin
            s_next.phase = s_reg.phase + 2'h1;
            bit_en = (s_reg.phase == `ULP_SAMPLE_PHASE);
        end
        se0 = !line_i.dp && !line_i.dm;
        rx_bit = (line_i.dp == s_reg.rx_last);

        // bit engine
        if (bit_en) begin
            case (s_reg.st)
                ulp_pkg::ST_IDLE: begin
                    if (s_reg.func_addr[`ULP_ADR_USBEN] && line_i.dp && !line_i.dm) begin
                        s_next.st = ulp_pkg::ST_SYNC;
                        s_next.rx_last = 1'b1;
                    end
                end
                ulp_pkg::ST_SYNC: begin
                    s_next.rx_last = line_i.dp;
                    if (se0) begin
                        s_next.st = ulp_pkg::ST_IDLE;
                    end else if (rx_bit) begin
                        s_next.st = ulp_pkg::ST_RECV;
                        s_next.ones = 3'h1;
                        s_next.bitcnt = 3'h0;
                        s_next.byte_idx = 4'h0;
                    end
                end
                ulp_pkg::ST_RECV: begin
                    s_next.rx_last = line_i.dp;
                    if (se0) begin
                        s_next.st = ulp_pkg::ST_IDLE;
                        s_next.rx_last = 1'b0;
                        tok_addr = s_reg.tk0[6:0];
                        tok_ep = {s_reg.shift[2:0], s_reg.tk0[7]};
                        is_setup = (s_reg.pid == `ULP_PID_SETUP);
                        is_in = (s_reg.pid == `ULP_PID_IN);
                        is_out = (s_reg.pid == `ULP_PID_OUT);
                        if ((is_setup || is_in || is_out) && s_reg.byte_idx == `ULP_TOKEN_BYTES
                            && tok_addr == s_reg.func_addr[6:0]) begin
                            if (tok_ep == 4'h0) begin
                                // all three flags written at once
                                s_next.status[`ULP_STA_SETUP] = is_setup; // R2 R14
                                s_next.status[`ULP_STA_IN] = is_in; // R3 R14
                                s_next.status[`ULP_STA_OUT] = is_out; // R4 R14
                                s_next.last_ep0_out = is_setup || is_out;
                            end else begin
                                s_next.last_ep0_out = 1'b0;
                            end
                            // shared register answers only the selected endpoint
                            ep1_go = tok_ep == 4'h1 && s_reg.ep_ctrl[`ULP_EPC_EP1E]
                                && !s_reg.ep1_tx_ctrl[`ULP_CTL1_EPSEL]; // R13
                            ep2_go = tok_ep == 4'h2 && s_reg.ep_ctrl[`ULP_EPC_EP2E]
                                && s_reg.ep1_tx_ctrl[`ULP_CTL1_EPSEL]; // R13
                            if (is_in && tok_ep == 4'h0 && s_reg.ep0_tx_ctrl[`ULP_CTL_TXE]) begin
                                s_next.st = ulp_pkg::ST_SEND;
                                s_next.tx_shift = {s_reg.ep0_tx_data,
                                    data_pid_byte(s_reg.ep0_tx_ctrl[`ULP_CTL_TSEQ]), `ULP_SYNC_BYTE}; // R7
                            end else if (is_in && (ep1_go || ep2_go) && s_reg.ep1_tx_ctrl[`ULP_CTL_TXE]) begin
                                s_next.st = ulp_pkg::ST_SEND;
                                s_next.tx_shift = {s_reg.ep1_tx_data,
                                    data_pid_byte(s_reg.ep1_tx_ctrl[`ULP_CTL_TSEQ]), `ULP_SYNC_BYTE}; // R8
                            end
                        end else if (s_reg.data_ok) begin
                            s_next.status[3:0] = s_reg.cnt; // R5
                            s_next.last_ep0_out = 1'b0;
                        end
                        s_next.data_ok = 1'b0;
                        // start driving from the idle level
                        if (s_next.st == ulp_pkg::ST_SEND) begin
                            s_next.tx_bits = 5'h00;
                            s_next.tx_ones = 3'h0;
                            s_next.drive = '{dp: 1'b0, dm: 1'b1};
                            s_next.oe_n = 1'b0; // R12
                        end
                    end else if (s_reg.ones == `ULP_STUFF_RUN) begin
                        s_next.ones = 3'h0; // stuffed zero dropped
                    end else begin
                        s_next.ones = rx_bit ? s_reg.ones + 3'h1 : 3'h0;
                        s_next.shift = {rx_bit, s_reg.shift[7:1]};
                        s_next.bitcnt = s_reg.bitcnt + 3'h1;
                        if (s_reg.bitcnt == 3'h7) begin
                            b = {rx_bit, s_reg.shift[7:1]};
                            if (s_reg.byte_idx != 4'hF) begin
                                s_next.byte_idx = s_reg.byte_idx + 4'h1;
                            end
                            if (s_reg.byte_idx == 4'h0) begin
                                s_next.pid = b[3:0];
                                s_next.cnt = 4'h0;
                                // expected against received pid
                                s_next.seq_match = (b[3] == s_reg.status[`ULP_STA_SEQ]); // R1
                                s_next.data_ok = s_reg.last_ep0_out
                                    && (is_pid(b, `ULP_PID_DATA0) || is_pid(b, `ULP_PID_DATA1))
                                    && (b[3] == s_reg.status[`ULP_STA_SEQ]); // R1
                            end else if (s_reg.byte_idx == 4'h1) begin
                                s_next.tk0 = b;
                            end
                            // two-byte holdback keeps the crc out of the buffer
                            if (s_reg.byte_idx >= 4'h3 && s_reg.data_ok) begin
                                fifo_in_valid = 1'b1; // R6
                                if (fifo_in_ready) begin
                                    s_next.cnt = s_reg.cnt + 4'h1; // R5
                                end
                            end
                            s_next.hold2 = s_reg.hold1;
                            s_next.hold1 = b;
                        end
                    end
                end
                ulp_pkg::ST_SEND: begin
                    // nrzi; stuff a zero after six ones
                    if (s_reg.tx_ones == `ULP_STUFF_RUN) begin
                        s_next.tx_ones = 3'h0;
                        s_next.drive = '{dp: !s_reg.drive.dp, dm: s_reg.drive.dp};
                    end else begin
                        tx_bit = s_reg.tx_shift[0];
                        s_next.tx_ones = tx_bit ? s_reg.tx_ones + 3'h1 : 3'h0;
                        if (!tx_bit) begin
                            s_next.drive = '{dp: !s_reg.drive.dp, dm: s_reg.drive.dp};
                        end
                        s_next.tx_shift = {1'b0, s_reg.tx_shift[23:1]};
                        s_next.tx_bits = s_reg.tx_bits + 5'h01;
                        if (s_reg.tx_bits == `ULP_TX_LAST_BIT) begin
                            s_next.st = ulp_pkg::ST_EOP;
                            s_next.eop_cnt = 2'h0;
                        end
                    end
                end
                ulp_pkg::ST_EOP: begin
                    // two se0 bits, one J, then release
                    s_next.eop_cnt = s_reg.eop_cnt + 2'h1;
                    case (s_reg.eop_cnt)
                        2'h0, 2'h1: s_next.drive = '{dp: 1'b0, dm: 1'b0};
                        2'h2: s_next.drive = '{dp: 1'b0, dm: 1'b1};
                        default: begin
                            s_next.oe_n = 1'b1; // R12
                            s_next.st = ulp_pkg::ST_IDLE;
                        end
                    endcase
                end
                default: begin
                    s_next.st = ulp_pkg::ST_IDLE;
                    s_next.oe_n = 1'b1; // R12
                end
            endcase
        end

        // register writes
        if (sfr_i.wr) begin
            case (sfr_i.addr)
                `ULP_ADDR_PRESCALER: s_next.prescaler = sfr_i.wdata; // R9
                `ULP_ADDR_EP1_TX_DATA: s_next.ep1_tx_data = sfr_i.wdata; // R8
                `ULP_ADDR_EP0_TX_DATA: s_next.ep0_tx_data = sfr_i.wdata; // R7
                `ULP_ADDR_EVENT_ENABLES: s_next.event_enables = sfr_i.wdata;
                `ULP_ADDR_EP0_TX_CTRL: s_next.ep0_tx_ctrl = sfr_i.wdata;
                `ULP_ADDR_EP1_TX_CTRL: s_next.ep1_tx_ctrl = sfr_i.wdata; // R13
                `ULP_ADDR_EP_CTRL: s_next.ep_ctrl = {3'b000, sfr_i.wdata[4:0]};
                `ULP_ADDR_EP0_STATUS: s_next.status[`ULP_STA_SEQ] = sfr_i.wdata[`ULP_STA_SEQ]; // R1
                `ULP_ADDR_FUNC_ADDR: s_next.func_addr = sfr_i.wdata;
                default: ;
            endcase
        end

        // reads answer a cycle later
        if (sfr_i.rd) begin
            case (sfr_i.addr)
                `ULP_ADDR_PRESCALER: s_next.rdata = s_reg.prescaler;
                `ULP_ADDR_EP1_TX_DATA: s_next.rdata = s_reg.ep1_tx_data;
                `ULP_ADDR_EP0_TX_DATA: s_next.rdata = s_reg.ep0_tx_data;
                `ULP_ADDR_EVENT_ENABLES: s_next.rdata = s_reg.event_enables;
                `ULP_ADDR_EP0_TX_CTRL: s_next.rdata = s_reg.ep0_tx_ctrl;
                `ULP_ADDR_EP1_TX_CTRL: s_next.rdata = s_reg.ep1_tx_ctrl;
                `ULP_ADDR_EP_CTRL: s_next.rdata = s_reg.ep_ctrl;
                `ULP_ADDR_EP0_STATUS: s_next.rdata = s_reg.status; // R2 R3 R4 R5
                `ULP_ADDR_FUNC_ADDR: s_next.rdata = s_reg.func_addr;
                `ULP_ADDR_EP0_RX_DATA: s_next.rdata = fifo_out_valid ? fifo_out_data : `ULP_RST_BYTE; // R6
                default: s_next.rdata = `ULP_RST_BYTE;
            endcase
        end
        usb_clk_en_o = usb_en;
    end

    // one state register
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
            s_reg.st <= ulp_pkg::ST_IDLE;
            s_reg.oe_n <= 1'b1; // R12
            s_reg.drive <= '{dp: 1'b0, dm: 1'b1};
            s_reg.status <= `ULP_RST_BYTE;
            s_reg.prescaler <= `ULP_RST_BYTE;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flops
    assign sfr_rdata_o = s_reg.rdata;
    assign line_o = s_reg.drive;
    assign line_oe_n_o = s_reg.oe_n; // R12
    assign ep0_rx_seq_match_o = s_reg.seq_match;
endmodule : ulp_core
`default_nettype wire

// file: test/ulp_props.sv
// Purpose: port checks of ulp_core
// Assumes: one clock, sync reset
// Notes: prescaler mirrored from writes
`timescale 1ns/1ps
`default_nettype none
module ulp_props (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // register port
    input wire ulp_pkg::ulp_sfr_req_type sfr_i,
    input wire logic [7:0] sfr_rdata_o,
    // line and status
    input wire ulp_pkg::ulp_line_type line_i,
    input wire logic line_oe_n_o,
    input wire logic usb_clk_en_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    logic [7:0] psc_reg;
    logic [8:0] gap_reg;
    logic gap_ok_reg;
    logic [16:0] low_reg;
    // first pulse after a prescaler write is skipped
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            psc_reg <= 8'h00;
            gap_reg <= 9'h000;
            gap_ok_reg <= 1'b0;
            low_reg <= 17'h0_0000;
        end else begin
            if (sfr_i.wr && sfr_i.addr == 8'hE1) begin
                psc_reg <= sfr_i.wdata;
            end
            gap_reg <= usb_clk_en_o ? 9'h000 : gap_reg + 9'h001;
            gap_ok_reg <= (sfr_i.wr && sfr_i.addr == 8'hE1) ? 1'b0 : (gap_ok_reg | usb_clk_en_o);
            low_reg <= line_oe_n_o ? 17'h0_0000 : low_reg + 17'h0_0001;
        end
    end
    a_unmapped_zero: assert property (sfr_i.rd && (sfr_i.addr inside {[8'h00:8'hE0], [8'hE2:8'hE5], 8'hE8})
        |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_rdata_stands: assert property (!sfr_i.rd |=> $stable(sfr_rdata_o)) else $error("read data moved");
    a_write_back: assert property ((sfr_i.wr && sfr_i.addr inside {8'hE6, 8'hE7}) ##1
        (sfr_i.rd && sfr_i.addr == $past(sfr_i.addr)) |=> sfr_rdata_o == $past(sfr_i.wdata, 2)) else $error("readback");
    a_seq_bit_rw: assert property ((sfr_i.wr && sfr_i.addr == 8'hED) ##1 (sfr_i.rd && sfr_i.addr == 8'hED)
        |=> sfr_rdata_o[7] == $past(sfr_i.wdata[7], 2)) else $error("seq readback");
    a_flags_one: assert property (sfr_i.rd && sfr_i.addr == 8'hED |=> $countones(sfr_rdata_o[6:4]) <= 1)
        else $error("more than one token flag");
    a_clk_period: assert property (usb_clk_en_o && gap_ok_reg |-> gap_reg == {psc_reg, 1'b1})
        else $error("clock enable period");
    a_oe_bounded: assert property (!line_oe_n_o |-> low_reg < 17'h0_0140 * ({9'h000, psc_reg} + 17'h0_0001))
        else $error("driver held too long");
    a_oe_at_eop: assert property ($fell(line_oe_n_o) |-> $past(line_i) == 2'b00)
        else $error("drive not after se0");
endmodule : ulp_props
bind ulp_core ulp_props u_props (.clock_i(clock_i), .nrst_i(nrst_i), .sfr_i(sfr_i), .sfr_rdata_o(sfr_rdata_o),
    .line_i(line_i), .line_oe_n_o(line_oe_n_o), .usb_clk_en_o(usb_clk_en_o));
`default_nettype wire

// file: test/ulp_host_model.sv
// Purpose: host controller sending packets
// Assumes: bit time fixed by BIT_CYC
// Notes: released line rests at J, driven by the model between packets
`timescale 1ns/1ps
`default_nettype none
`include "ulp_params.svh"
module ulp_host_model #(
    parameter int BIT_CYC = 8
) (
    // clock
    input wire logic clock_i,
    // line toward the block
    output var ulp_pkg::ulp_line_type line_o
);
    logic lvl = 1'b0;
    logic se0 = 1'b0;
    // dp low, dm high is J
    assign line_o = se0 ? 2'b00 : {lvl, ~lvl};
    task automatic hold_bit();
        repeat (BIT_CYC) @(negedge clock_i);
    endtask : hold_bit
    // nrzi, stuffed zero after six ones, lsb first behind the sync
    task automatic send_packet(input logic [63:0] bytes, input int n);
        logic [71:0] word;
        int ones;
        word = {bytes, `ULP_SYNC_BYTE};
        ones = 0;
        for (int i = 0; i < 8 * (n + 1); i++) begin
            ones = word[i] ? ones + 1 : 0;
            lvl = word[i] ? lvl : ~lvl;
            hold_bit();
            if (ones == 6) begin
                lvl = ~lvl;
                ones = 0;
                hold_bit();
            end
        end
        se0 = 1'b1;
        repeat (2) hold_bit();
        se0 = 1'b0;
        lvl = 1'b0;
        hold_bit();
    endtask : send_packet
endmodule : ulp_host_model
`default_nettype wire

// file: test/ulp_core_tb.sv
// Purpose: bench of ulp_core
// Assumes: prescaler 0, eight cycles a bit
// Notes: line muxed by driver enable
`timescale 1ns/1ps
`default_nettype none
`include "ulp_params.svh"
module ulp_core_tb;
    localparam logic [6:0] ADR = 7'h25;
    localparam logic [23:0] WTR [7] = '{24'hE7_A5A5, 24'hE6_3C3C, 24'hED_FF80, 24'hEC_FF1F, 24'hEF_5500,
        24'hE8_FF00, 24'hED_0000};
    localparam logic [47:0] SND [3] = '{48'h2000_0000_5AC3, 48'h00A0_0401_3C4B, 48'h0060_0802_3CC3};
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    ulp_pkg::ulp_sfr_req_type sfr = '0;
    ulp_pkg::ulp_line_type host_line, dut_line, line_in;
    logic [7:0] rdata;
    logic oe_n, clk_en, seq_match;
    int bad_count = 0;
    int checked = 0;
    always #2.5 clock_i = ~clock_i;
    // block drives, else host
    assign line_in = oe_n ? host_line : dut_line;
    ulp_core u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .sfr_i(sfr), .sfr_rdata_o(rdata), .line_i(line_in),
        .line_o(dut_line), .line_oe_n_o(oe_n), .usb_clk_en_o(clk_en), .ep0_rx_seq_match_o(seq_match));
    ulp_host_model #(.BIT_CYC(8)) u_host (.clock_i(clock_i), .line_o(host_line));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one access, one cycle long
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge clock_i);
        sfr = '{a, d, w, ~w};
        @(negedge clock_i);
        sfr = '0;
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        acc(a, 8'h00, 1'b0);
        check(rdata, exp);
    endtask : rd
    task automatic token(input logic [3:0] pid, input logic [6:0] a, input logic [3:0] ep);
        u_host.send_packet(64'({5'h00, ep[3:1], ep[0], a, ~pid, pid}), 3);
    endtask : token
    task automatic t_regs();
        for (int a = 8'hE0; a <= 8'hF0; a++) rd(8'(a), 8'h00);
        check({7'h00, oe_n}, 8'h01);
        foreach (WTR[i]) begin
            @(negedge clock_i);
            sfr = '{WTR[i][23:16], WTR[i][15:8], 1'b1, 1'b0};
            @(negedge clock_i);
            {sfr.wr, sfr.rd} = 2'b01;
            @(negedge clock_i);
            sfr = '0;
            check(rdata, WTR[i][7:0]);
        end
        $display("test regs done");
    endtask : t_regs
    task automatic t_tokens();
        acc(8'hEE, {1'b1, ADR}, 1'b1);
        token(`ULP_PID_SETUP, ADR, 4'h0);
        rd(8'hED, 8'h40);
        token(`ULP_PID_IN, ADR, 4'h0);
        rd(8'hED, 8'h20);
        token(`ULP_PID_OUT, ADR, 4'h0);
        rd(8'hED, 8'h10);
        token(`ULP_PID_IN, ADR + 7'h01, 4'h0);
        rd(8'hED, 8'h10);
        $display("test tokens done");
    endtask : t_tokens
    task automatic t_data();
        u_host.send_packet(64'({24'h33_2211, ~`ULP_PID_DATA0, `ULP_PID_DATA0}), 6);
        check({7'h00, seq_match}, 8'h01);
        rd(8'hED, 8'h13);
        for (int i = 1; i < 5; i++) rd(8'hEF, (i < 4) ? 8'(i * 8'h11) : 8'h00);
        u_host.send_packet(64'({8'h77, ~`ULP_PID_DATA1, `ULP_PID_DATA1}), 4);
        check({7'h00, seq_match}, 8'h00);
        rd(8'hED, 8'h13);
        rd(8'hEF, 8'h00);
        acc(8'hED, 8'h80, 1'b1);
        token(`ULP_PID_OUT, ADR, 4'h0);
        u_host.send_packet(64'({16'h5544, ~`ULP_PID_DATA1, `ULP_PID_DATA1}), 5);
        rd(8'hED, 8'h92);
        rd(8'hEF, 8'h44);
        rd(8'hEF, 8'h55);
        $display("test data done");
    endtask : t_data
    task automatic t_send();
        logic [23:0] got;
        logic prev;
        acc(8'hE7, 8'h5A, 1'b1);
        acc(8'hE6, 8'h3C, 1'b1);
        foreach (SND[i]) begin
            for (int k = 0; k < 3; k++) acc(8'hEA + 8'(k), SND[i][47-8*k-:8], 1'b1);
            prev = 1'b0;
            fork
                token(`ULP_PID_IN, ADR, SND[i][19:16]);
                begin
                    @(negedge oe_n);
                    repeat (12) @(negedge clock_i);
                    for (int b = 0; b < 24; b++) begin
                        got[b] = (dut_line.dp == prev);
                        prev = dut_line.dp;
                        repeat (8) @(negedge clock_i);
                    end
                end
            join
            for (int k = 0; k < 64 && oe_n !== 1'b1; k++) @(negedge clock_i);
            check({got[7:0], got[15:8], got[23:16], 7'h00, oe_n}, {`ULP_SYNC_BYTE, SND[i][7:0], SND[i][15:8], 8'h01});
        end
        $display("test send done");
    endtask : t_send
    task automatic t_prescale();
        int n;
        for (int p = 0; p < 3; p++) begin
            acc(8'hE1, 8'(p), 1'b1);
            repeat (2) @(negedge clock_i iff clk_en);
            n = 0;
            do begin
                @(negedge clock_i);
                n++;
            end while (!clk_en);
            check(8'(n), 8'(2 * (p + 1)));
        end
        $display("test prescale done");
    endtask : t_prescale
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (6) @(negedge clock_i);
        nrst_i = 1'b1;
        t_regs();
        t_tokens();
        t_data();
        t_send();
        t_prescale();
        tally_and_finish();
    end
    // watchdog, about nine times the run
    initial begin
        #200us;
        bad_count++;
        tally_and_finish();
    end
endmodule : ulp_core_tb
`default_nettype wire
